// *** pcm_pkg.sv ***
package pcm_pkg;
   localparam int unsigned DATA_W       = 14;
   localparam int unsigned NUM_PWM      = 4;
   localparam int unsigned NUM_FE       = 3;
   localparam int unsigned NUM_FILT     = 2;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned RAMP_STEP_NS = 32;
   localparam int unsigned RAMP_DIV     = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIV_W        = 2;
   localparam logic [2:0]  MODE_W_PEAK  = 3'h5;

   localparam logic [11:0] OFS_SLOPE    = 12'h000;
   localparam logic [11:0] OFS_END      = 12'h004;
   localparam logic [11:0] OFS_ECTRL    = 12'h008;
   localparam logic [11:0] OFS_PCTRL    = 12'h00c;
   localparam logic [11:0] OFS_LIMIT    = 12'h010;
   localparam logic [11:0] OFS_TRIG     = 12'h014;
   localparam logic [11:0] OFS_STATUS   = 12'h018;

   localparam int unsigned ECTRL_D2S    = 0;
   localparam int unsigned ECTRL_MODE   = 4;
   localparam int unsigned PCTRL_EN     = 0;
   localparam int unsigned PCTRL_FE     = 4;
   localparam int unsigned PCTRL_FILT   = 8;
   localparam int unsigned ST_RAMP      = 0;
   localparam int unsigned ST_TRIP      = 1;
   localparam int unsigned ST_LEVEL     = 16;
   localparam logic [1:0]  FE_SEL_RST   = 2'h2;
endpackage

// *** pcm_ramp.sv ***
`timescale 1ns/10ps
`default_nettype none
module pcm_ramp (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        start,
   input  wire logic                        step_en,
   input  wire logic [pcm_pkg::DATA_W-1:0]  start_val,
   input  wire logic [pcm_pkg::DATA_W-1:0]  slope,
   input  wire logic [pcm_pkg::DATA_W-1:0]  end_val,
   output logic      [pcm_pkg::DATA_W-1:0]  level_r,
   output logic                             running_r
);
   logic [pcm_pkg::DATA_W:0] sum;
   logic                     hit_end;
   logic                     end_on;
   assign sum     = {1'b0, level_r} + {1'b0, slope};
   assign end_on  = end_val != '0;
   // Saturate at the end value; zero end means unbounded (optional)
   assign hit_end = sum[pcm_pkg::DATA_W] || (end_on && sum[pcm_pkg::DATA_W-1:0] >= end_val);

   always_ff @(posedge clk) begin
      if (rst) begin
         level_r   <= '0;
         running_r <= 1'b0;
      end else if (start) begin
         level_r   <= start_val;
         running_r <= 1'b1;
      end else if (running_r && step_en) begin
         if (hit_end) begin
            level_r   <= end_on ? end_val : {pcm_pkg::DATA_W{1'b1}};
            running_r <= 1'b0;
         end else begin
            level_r <= sum[pcm_pkg::DATA_W-1:0];
         end
      end
   end
endmodule // pcm_ramp
`default_nettype wire

// *** pcm_path.sv ***
// Operation
// - A programmable ramp end value bounds the ramp; zero leaves it unbounded.
// - The single-ended comparator works only while the diff-to-single enable bit is set.
// - Error converter mode 5 puts the front end into peak current mode.
// - A front end select field picks which of three front ends feeds the peak path.
// - The peak path enable bit gates the selected comparator output.
// - Each of four PWM generators has its own enable routing the trip to its limit input.
// - A per-PWM frame trigger enable starts the ramp at that generator's period start.
// - There is exactly one peak current module, fed by any front end.
// - The comparator trips when the ramp exceeds the sensed primary current.
// - Each trigger-enabled frame restarts the ramp, which advances one step every 32 ns.
// - The slope register gives the DAC increment per ramp step.
// - A filter select picks filter 0 or filter 1 as ramp start value.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module pcm_path (
   input  wire logic                                      clk,
   input  wire logic                                      rst,
   input  wire logic                                      psel,
   input  wire logic                                      penable,
   input  wire logic                                      pwrite,
   input  wire logic [11:0]                               paddr,
   input  wire logic [31:0]                               pwdata,
   output logic      [31:0]                               prdata,
   output logic                                           pready,
   output logic                                           pslverr,
   input  wire logic [pcm_pkg::NUM_FE*pcm_pkg::DATA_W-1:0] fe_current,
   input  wire logic [pcm_pkg::DATA_W-1:0]                filt0_out,
   input  wire logic [pcm_pkg::DATA_W-1:0]                filt1_out,
   input  wire logic [pcm_pkg::NUM_PWM-1:0]               pwm_frame_start,
   output logic      [pcm_pkg::NUM_PWM-1:0]               current_limit_input
);
   logic [pcm_pkg::DATA_W-1:0] ramp_slope_step_r;
   logic [pcm_pkg::DATA_W-1:0] ramp_end_value_r;
   logic                       diff_to_single_enable_r;
   logic [2:0]                 error_conv_mode_field_r;
   logic                       peak_enable_r;
   logic [1:0]                 peak_front_end_select_r;
   logic                       filt_sel_r;
   logic [pcm_pkg::NUM_PWM-1:0] pwm_limit_routing_r;
   logic [pcm_pkg::NUM_PWM-1:0] pwm_frame_trigger_enable_r;
   logic [pcm_pkg::DIV_W-1:0]  div_r;
   logic                       step_en_r;
   logic                       trip_r;
   logic [pcm_pkg::DATA_W-1:0] ramp_level;
   logic                       ramp_running;

   wire wr_en = psel && penable && pwrite;
   wire rd_ok = paddr == pcm_pkg::OFS_SLOPE || paddr == pcm_pkg::OFS_END || paddr == pcm_pkg::OFS_ECTRL
             || paddr == pcm_pkg::OFS_PCTRL || paddr == pcm_pkg::OFS_LIMIT || paddr == pcm_pkg::OFS_TRIG
             || paddr == pcm_pkg::OFS_STATUS;
   wire [31:0] rd_mux =
      paddr == pcm_pkg::OFS_SLOPE  ? 32'(ramp_slope_step_r) :
      paddr == pcm_pkg::OFS_END    ? 32'(ramp_end_value_r) :
      paddr == pcm_pkg::OFS_ECTRL  ? (32'(diff_to_single_enable_r) << pcm_pkg::ECTRL_D2S)
                                   | (32'(error_conv_mode_field_r) << pcm_pkg::ECTRL_MODE) :
      paddr == pcm_pkg::OFS_PCTRL  ? (32'(peak_enable_r) << pcm_pkg::PCTRL_EN)
                                   | (32'(peak_front_end_select_r) << pcm_pkg::PCTRL_FE)
                                   | (32'(filt_sel_r) << pcm_pkg::PCTRL_FILT) :
      paddr == pcm_pkg::OFS_LIMIT  ? 32'(pwm_limit_routing_r) :
      paddr == pcm_pkg::OFS_TRIG   ? 32'(pwm_frame_trigger_enable_r) :
      paddr == pcm_pkg::OFS_STATUS ? (32'(ramp_running) << pcm_pkg::ST_RAMP)
                                   | (32'(trip_r) << pcm_pkg::ST_TRIP)
                                   | (32'(ramp_level) << pcm_pkg::ST_LEVEL) : 32'h0;

   // Single shared module: only one front end reaches the comparator
   wire [pcm_pkg::DATA_W-1:0] sel_current =
      peak_front_end_select_r == 2'h0 ? fe_current[0 +: pcm_pkg::DATA_W] :
      peak_front_end_select_r == 2'h1 ? fe_current[pcm_pkg::DATA_W +: pcm_pkg::DATA_W] :
      fe_current[2*pcm_pkg::DATA_W +: pcm_pkg::DATA_W];
   wire [pcm_pkg::DATA_W-1:0] start_val = filt_sel_r ? filt1_out : filt0_out;
   wire ramp_start = |(pwm_frame_start & pwm_frame_trigger_enable_r);
   wire mode_peak  = error_conv_mode_field_r == pcm_pkg::MODE_W_PEAK;
   wire trip_nxt   = mode_peak && diff_to_single_enable_r && peak_enable_r
                     && ramp_running && ramp_level > sel_current;

   always_ff @(posedge clk) begin
      if (rst) begin
         ramp_slope_step_r          <= '0;
         ramp_end_value_r           <= '0;
         diff_to_single_enable_r    <= 1'b0;
         error_conv_mode_field_r    <= '0;
         peak_enable_r              <= 1'b0;
         peak_front_end_select_r    <= pcm_pkg::FE_SEL_RST;
         filt_sel_r                 <= 1'b0;
         pwm_limit_routing_r        <= '0;
         pwm_frame_trigger_enable_r <= '0;
      end else if (wr_en) begin
         unique case (paddr)
            pcm_pkg::OFS_SLOPE: ramp_slope_step_r <= pwdata[pcm_pkg::DATA_W-1:0];
            pcm_pkg::OFS_END:   ramp_end_value_r <= pwdata[pcm_pkg::DATA_W-1:0];
            pcm_pkg::OFS_ECTRL: begin
               diff_to_single_enable_r <= pwdata[pcm_pkg::ECTRL_D2S];
               error_conv_mode_field_r <= pwdata[pcm_pkg::ECTRL_MODE +: 3];
            end
            pcm_pkg::OFS_PCTRL: begin
               peak_enable_r <= pwdata[pcm_pkg::PCTRL_EN];
               // Front end 3 does not exist; keep the old choice
               if (pwdata[pcm_pkg::PCTRL_FE +: 2] != 2'h3) begin
                  peak_front_end_select_r <= pwdata[pcm_pkg::PCTRL_FE +: 2];
               end
               filt_sel_r <= pwdata[pcm_pkg::PCTRL_FILT];
            end
            pcm_pkg::OFS_LIMIT: pwm_limit_routing_r <= pwdata[pcm_pkg::NUM_PWM-1:0];
            pcm_pkg::OFS_TRIG:  pwm_frame_trigger_enable_r <= pwdata[pcm_pkg::NUM_PWM-1:0];
            default: ;
         endcase
      end
   end

   // Step divider; restarts with each trigger-enabled frame so steps stay aligned to the frame
   wire [pcm_pkg::DIV_W-1:0] div_last = pcm_pkg::DIV_W'(pcm_pkg::RAMP_DIV - 1);
   wire [pcm_pkg::DIV_W-1:0] div_nxt  = (div_r == div_last) ? '0 : div_r + 1'b1;

   // Pulse decoded from the next count, so the first step comes one full step after the load
   always_ff @(posedge clk) begin
      if (rst || ramp_start) begin
         div_r     <= '0;
         step_en_r <= 1'b0;
      end else begin
         div_r     <= div_nxt;
         step_en_r <= div_nxt == div_last;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         trip_r              <= 1'b0;
         current_limit_input <= '0;
         prdata              <= '0;
         pready              <= 1'b0;
         pslverr             <= 1'b0;
      end else begin
         trip_r              <= trip_nxt;
         current_limit_input <= {pcm_pkg::NUM_PWM{trip_nxt}} & pwm_limit_routing_r;
         pready              <= psel && !penable;
         pslverr             <= psel && !penable && !rd_ok;
         prdata              <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
      end
   end

   pcm_ramp u_ramp (
      .clk       (clk),
      .rst       (rst),
      .start     (ramp_start),
      .step_en   (step_en_r),
      .start_val (start_val),
      .slope     (ramp_slope_step_r),
      .end_val   (ramp_end_value_r),
      .level_r   (ramp_level),
      .running_r (ramp_running)
   );

   property p_route;
      @(posedge clk) disable iff (rst) current_limit_input != '0 |-> (current_limit_input & ~$past(pwm_limit_routing_r)) == '0;
   endproperty
   a_route: assert property (p_route) else $error("limit routed to disabled pwm");

   property p_gate;
      @(posedge clk) disable iff (rst) current_limit_input != '0 |-> $past(peak_enable_r) && $past(diff_to_single_enable_r);
   endproperty
   a_gate: assert property (p_gate) else $error("trip while path disabled");

   property p_mode;
      @(posedge clk) disable iff (rst) trip_r |-> $past(error_conv_mode_field_r) == pcm_pkg::MODE_W_PEAK;
   endproperty
   a_mode: assert property (p_mode) else $error("trip outside peak mode");

   property p_start;
      @(posedge clk) disable iff (rst) ramp_start |=> ramp_level == $past(start_val) && ramp_running;
   endproperty
   a_start: assert property (p_start) else $error("ramp did not load start value");

   // Load edge, then four quiet cycles: the level must still be the loaded start value
   sequence s_load_then_quiet;
      ramp_start ##1 (!ramp_start) [*4];
   endsequence

   property p_step;
      @(posedge clk) disable iff (rst) s_load_then_quiet |-> ramp_level == $past(ramp_level, 3);
   endproperty
   a_step: assert property (p_step) else $error("ramp stepped before 32 ns");

   property p_end;
      @(posedge clk) disable iff (rst) ramp_end_value_r != '0 && !ramp_start && $past(!ramp_start) && !$past(ramp_running)
         |-> ramp_level <= ramp_end_value_r || ramp_level == $past(ramp_level);
   endproperty
   a_end: assert property (p_end) else $error("ramp moved after end");

   property p_cmp;
      @(posedge clk) disable iff (rst) trip_r |-> $past(ramp_level) > $past(sel_current);
   endproperty
   a_cmp: assert property (p_cmp) else $error("trip without ramp above current");

   property p_trig;
      @(posedge clk) disable iff (rst) (pwm_frame_start & pwm_frame_trigger_enable_r) == '0 && !ramp_running |=> !ramp_running;
   endproperty
   a_trig: assert property (p_trig) else $error("ramp started without enabled frame");
endmodule // pcm_path
`default_nettype wire

// *** pcm_pwm_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module pcm_pwm_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [3:0] kick,
   input  wire logic [3:0] limit,
   output logic      [3:0] frame_start,
   output logic      [3:0] chopped_r
);
   // Frame pulses last one cycle, as a real period counter would give them
   always_ff @(posedge clk) begin
      if (rst) begin
         frame_start <= 4'h0;
         chopped_r   <= 4'h0;
      end else begin
         frame_start <= kick;
         chopped_r   <= (chopped_r & ~frame_start) | limit;
      end
   end
endmodule // pcm_pwm_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr;
   logic [41:0] fe_cur = {14'h0130, 14'h0050, 14'h3fff};
   logic [13:0] filt0 = 14'h0100, filt1 = 14'h0200;
   logic [3:0]  kick = 4'h0, frame, limit;
   int          errors = 0, total_checks = 0, cycles = 0;

   always #4 clk = ~clk;

   pcm_path pcm_path_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fe_current(fe_cur), .filt0_out(filt0), .filt1_out(filt1), .pwm_frame_start(frame),
      .current_limit_input(limit));
   pcm_pwm_model pcm_pwm_model_i (.clk(clk), .rst(rst), .kick(kick), .limit(limit),
      .frame_start(frame), .chopped_r());

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, exp_err});
   endtask

   task automatic test_regs;
      rd_chk(pcm_pkg::OFS_PCTRL, 32'h0000_0020, 1'b0);
      rd_chk(pcm_pkg::OFS_SLOPE, 32'h0000_0000, 1'b0);
      wr(12'h01c, 32'hffff_ffff);
      rd_chk(12'h01c, 32'h0000_0000, 1'b1);
      wr(pcm_pkg::OFS_SLOPE, 32'hffff_0010);
      rd_chk(pcm_pkg::OFS_SLOPE, 32'h0000_0010, 1'b0);
   endtask

   // One frame on generator 0; limit is judged before and after the ramp crosses the current
   task automatic frame_case(input logic [31:0] ec, pc, lm, tg, en, input logic [3:0] e0, e1);
      wr(pcm_pkg::OFS_END, en);
      wr(pcm_pkg::OFS_ECTRL, ec);
      wr(pcm_pkg::OFS_PCTRL, pc);
      wr(pcm_pkg::OFS_LIMIT, lm);
      wr(pcm_pkg::OFS_TRIG, tg);
      @(posedge clk);
      kick <= 4'h1;
      @(posedge clk);
      kick <= 4'h0;
      repeat (12) @(posedge clk);
      chk({28'h0, limit}, {28'h0, e0});
      repeat (14) @(posedge clk);
      chk({28'h0, limit}, {28'h0, e1});
   endtask

   task automatic test_path;
      frame_case(32'h51, 32'h21, 32'hf, 32'h1, 32'h0, 4'h0, 4'hf);
      frame_case(32'h51, 32'h21, 32'h5, 32'h1, 32'h0, 4'h0, 4'h5);
      frame_case(32'h51, 32'h20, 32'hf, 32'h1, 32'h0, 4'h0, 4'h0);
      frame_case(32'h41, 32'h21, 32'hf, 32'h1, 32'h0, 4'h0, 4'h0);
      frame_case(32'h50, 32'h21, 32'hf, 32'h1, 32'h0, 4'h0, 4'h0);
      frame_case(32'h51, 32'h121, 32'hf, 32'h1, 32'h0, 4'hf, 4'hf);
      frame_case(32'h51, 32'h01, 32'hf, 32'h1, 32'h0, 4'h0, 4'h0);
      // Front end code 3 must leave front end 0 in place; taking it would reach the low current
      frame_case(32'h51, 32'h31, 32'hf, 32'h1, 32'h0, 4'h0, 4'h0);
      frame_case(32'h51, 32'h11, 32'hf, 32'h1, 32'h0, 4'hf, 4'hf);
      frame_case(32'h51, 32'h21, 32'hf, 32'h1, 32'h120, 4'h0, 4'h0);
      frame_case(32'h51, 32'h21, 32'hf, 32'he, 32'h0, 4'h0, 4'h0);
      rd_chk(pcm_pkg::OFS_STATUS, 32'h0120_0000, 1'b0);
   endtask

   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Cuts a hang well past the expected run of a few hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      test_regs();
      test_path();
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
